// ### mfm_pkg.sv
/*
  Package for the motor fault manager: response codes, output FET states,
  motor control states and the timing figures used by the fault timers.
  Assumes a single 50 MHz clock; every time below is turned into cycles
  or millisecond ticks by the module that uses it.
*/
package mfm_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 20;
  localparam int MS_TICK_NS      = 1000000;
  localparam int MS_TICK_CYCLES  = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int OPEN_PHASE_MS   = 500;
  // Speed is in units of 0.1 Hz; the open-phase check needs 2 Hz or more.
  localparam int MIN_SPEED_DHZ   = 20;

  // ==========================================================================
  // Response selector codes (three-bit lock and current-limit fields)
  // ==========================================================================
  localparam logic [2:0] RSP_LATCH_OFF  = 3'h0;
  localparam logic [2:0] RSP_LATCH_LOW  = 3'h1;
  localparam logic [2:0] RSP_LATCH_HIGH = 3'h2;
  localparam logic [2:0] RSP_RETRY_OFF  = 3'h3;
  localparam logic [2:0] RSP_RETRY_LOW  = 3'h4;
  localparam logic [2:0] RSP_RETRY_HIGH = 3'h5;
  localparam logic [2:0] RSP_REPORT     = 3'h6;
  localparam logic [2:0] RSP_DISABLED   = 3'h7;

  // One-bit selectors: 0 latches and tri-states, 1 reports or auto-clears.
  localparam logic       SEL_LATCH      = 1'b0;

  // ==========================================================================
  // Output FET state
  // ==========================================================================
  typedef enum logic [1:0] {
    MFM_FET_NORMAL = 2'h0,
    MFM_FET_OFF    = 2'h1,
    MFM_FET_LOW    = 2'h2,
    MFM_FET_HIGH   = 2'h3
  } mfm_fet_t;

  // ==========================================================================
  // Motor control state reported by the speed loop
  // ==========================================================================
  typedef enum logic [2:0] {
    MFM_MS_IDLE   = 3'h0,
    MFM_MS_IPD    = 3'h1,
    MFM_MS_ALIGN  = 3'h2,
    MFM_MS_DALIGN = 3'h3,
    MFM_MS_OPEN   = 3'h4,
    MFM_MS_CLOSED = 3'h5
  } mfm_motor_state_t;

  // ==========================================================================
  // Rotor lock response state, Gray coded along idle, hold, retry
  // ==========================================================================
  typedef enum logic [1:0] {
    MFM_LK_IDLE  = 2'h0,
    MFM_LK_HOLD  = 2'h1,
    MFM_LK_RETRY = 2'h3
  } mfm_lock_state_t;

endpackage : mfm_pkg

// ### mfm_motor_fault_manager.sv
/*
  Motor fault manager: lock detectors, rotor lock response, current limit
  report, NVM check, I2C CRC fault and supply undervoltage handling.
  Assumes all inputs are synchronous to clk_i, condition inputs are already
  deglitched, and the fault pin is an open-drain wire pulled up outside.
*/
// Notes on behaviour
// - Current-limit mode 110b reports limit faults, drivers keep running.
// - Current-limit mode 111b ignores the limit completely.
// - Each lock detector has its own enable; disabled ones never fire.
// - Overspeed lock fires while enabled and speed exceeds threshold.
// - Back-EMF lock fires after mismatch persists for programmed time.
// - Open-phase lock fires when a phase current stays low 500 ms.
// - Open-phase check only in open or closed loop, speed 2 Hz up.
// - Closed-loop disable bit blocks open-phase check in closed loop.
// - Any enabled detector raises one rotor lock event handled by mode.
// - Latched lock modes pull fault pin, set bits, force FET state.
// - Latched lock releases only after condition gone and a clear.
// - Auto lock modes force FETs, then recover after retry time.
// - Lock mode 110b only reports; clears on clear with condition gone.
// - Lock mode 111b does nothing on a lock event.
// - Every NVM read checks CRC and parity; mismatch raises NVM fault.
// - NVM mode 0 pulls pin, tri-states FETs, holds until cleared.
// - NVM mode 1 reports only; a clear releases pin and bits.
// - NVM read is requested at power-up and at every wake-up.
// - NVM writes accepted in fault; successful write stores new CRC.
// - Enabled I2C CRC mismatch sets bits, pin; mode 0 tri-states FETs.
// - Undervoltage mode 0 latches until clear; mode 1 clears with hysteresis.
`timescale 1ns/1ps
module mfm_motor_fault_manager import mfm_pkg::*; #(
  parameter int SPD_W     = 16,
  parameter int CUR_W     = 12,
  parameter int VLT_W     = 16,
  parameter int CRC_W     = 8,
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             fault_clear_cmd_i,
  input  wire logic [2:0]       current_limit_response_sel_i,
  input  wire logic             adc_current_limit_i,
  input  wire logic             overspeed_detect_en_i,
  input  wire logic             backemf_detect_en_i,
  input  wire logic             open_phase_detect_en_i,
  input  wire logic [SPD_W-1:0] motor_speed_i,
  input  wire logic [SPD_W-1:0] overspeed_threshold_i,
  input  wire logic [SPD_W-1:0] backemf_error_i,
  input  wire logic [SPD_W-1:0] backemf_mismatch_threshold_i,
  input  wire logic [15:0]      backemf_persist_ms_i,
  input  wire logic [3*CUR_W-1:0] phase_current_i,
  input  wire logic [CUR_W-1:0] open_phase_current_threshold_i,
  input  wire logic [2:0]       motor_state_i,
  input  wire logic             open_phase_closedloop_disable_i,
  input  wire logic [2:0]       rotor_lock_response_sel_i,
  input  wire logic [15:0]      lock_retry_time_i,
  input  wire logic             wake_i,
  input  wire logic             nvm_read_done_i,
  input  wire logic [CRC_W-1:0] nvm_read_crc_i,
  input  wire logic             nvm_parity_ok_i,
  input  wire logic             nvm_write_done_i,
  input  wire logic [CRC_W-1:0] nvm_write_crc_i,
  input  wire logic             nvm_fault_response_sel_i,
  input  wire logic             i2c_crc_en_i,
  input  wire logic             i2c_pkt_done_i,
  input  wire logic             i2c_crc_ok_i,
  input  wire logic             crc_err_response_sel_i,
  input  wire logic [VLT_W-1:0] supply_voltage_i,
  input  wire logic [VLT_W-1:0] supply_low_threshold_i,
  input  wire logic [VLT_W-1:0] supply_hysteresis_i,
  input  wire logic             supply_low_response_sel_i,
  output logic                  nvm_read_req_o,
  output logic                  fault_out_n_o,
  output logic                  fault_out_n_oe_o,
  output logic [1:0]            fet_mode_o,
  output logic                  controller_fault_o,
  output logic                  current_limit_status_o,
  output logic                  rotor_lock_status_o,
  output logic                  overspeed_event_o,
  output logic                  backemf_mismatch_event_o,
  output logic                  open_phase_event_o,
  output logic                  nvm_error_status_o,
  output logic                  i2c_crc_status_o,
  output logic                  supply_low_status_o
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  function automatic mfm_fet_t fet_of(input logic [2:0] sel);
    case (sel)
      RSP_LATCH_LOW, RSP_RETRY_LOW:   fet_of = MFM_FET_LOW;
      RSP_LATCH_HIGH, RSP_RETRY_HIGH: fet_of = MFM_FET_HIGH;
      RSP_LATCH_OFF, RSP_RETRY_OFF:   fet_of = MFM_FET_OFF;
      default:                        fet_of = MFM_FET_NORMAL;
    endcase
  endfunction : fet_of

  function automatic logic is_retry(input logic [2:0] sel);
    is_retry = (sel >= RSP_RETRY_OFF) && (sel <= RSP_RETRY_HIGH);
  endfunction : is_retry

  // ==========================================================================
  // Condition detection
  // ==========================================================================
  logic [2:0] phase_low;
  logic       clr_pulse;
  logic       ms_tick;
  logic       ovs_cond;
  logic       bemf_high;
  logic       op_qual;
  logic       op_low;
  logic       bemf_ev;
  logic       op_ev;
  logic       lock_ev;
  logic       supply_low;
  logic       supply_ok;
  logic       nvm_bad;
  logic       i2c_bad;

  // Each phase is compared on its own; any low phase counts.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      assign phase_low[gi] =
        phase_current_i[gi*CUR_W +: CUR_W] < open_phase_current_threshold_i;
    end
  endgenerate

  // Registered state, declared ahead of the combinational logic.
  logic                  clr_d_ff, boot_ff, req_ff;
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt_ff, nxt_ms_cnt;
  logic [15:0]           bemf_ms_ff, nxt_bemf_ms;
  logic [9:0]            op_ms_ff, nxt_op_ms;
  logic [15:0]           retry_ms_ff, nxt_retry_ms;
  mfm_lock_state_t       lk_ff, nxt_lk;
  logic [2:0]            lk_sel_ff, nxt_lk_sel;
  logic [2:0]            lk_bits_ff, nxt_lk_bits;
  logic                  ilim_ff, nxt_ilim;
  logic                  nvm_ff, nxt_nvm;
  logic                  i2c_ff, nxt_i2c;
  logic                  uv_ff, nxt_uv;
  logic [CRC_W-1:0]      crc_ff, nxt_crc;
  mfm_fet_t              fet_ff, nxt_fet;
  logic                  pin_ff, nxt_pin;

  // Clear is taken on its rising edge so a held bit clears only once.
  assign clr_pulse  = fault_clear_cmd_i & ~clr_d_ff;
  assign ms_tick    = (ms_cnt_ff == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  assign ovs_cond   = overspeed_detect_en_i &
                      (motor_speed_i > overspeed_threshold_i);
  assign bemf_high  = backemf_detect_en_i &
                      (backemf_error_i > backemf_mismatch_threshold_i);
  // Start-up states and low speed give no usable phase current picture.
  assign op_qual    = open_phase_detect_en_i &
                      (motor_speed_i >= SPD_W'(MIN_SPEED_DHZ)) &
                      ((motor_state_i == MFM_MS_OPEN) |
                       ((motor_state_i == MFM_MS_CLOSED) &
                        ~open_phase_closedloop_disable_i));
  assign op_low     = op_qual & (|phase_low);
  assign bemf_ev    = bemf_high & (bemf_ms_ff >= backemf_persist_ms_i);
  assign op_ev      = op_low & (op_ms_ff == 10'(OPEN_PHASE_MS));
  assign lock_ev    = ovs_cond | bemf_ev | op_ev;
  assign supply_low = supply_voltage_i <= supply_low_threshold_i;
  assign supply_ok  = {1'b0, supply_voltage_i} >
                      ({1'b0, supply_low_threshold_i} +
                       {1'b0, supply_hysteresis_i});
  assign nvm_bad    = nvm_read_done_i &
                      ((nvm_read_crc_i != crc_ff) | ~nvm_parity_ok_i);
  assign i2c_bad    = i2c_crc_en_i & i2c_pkt_done_i & ~i2c_crc_ok_i;

  // ==========================================================================
  // Next-state logic for all fault state
  // ==========================================================================
  always_comb begin
    nxt_ms_cnt   = ms_tick ? '0 : ms_cnt_ff + 1'b1;
    nxt_bemf_ms  = bemf_ms_ff;
    nxt_op_ms    = op_ms_ff;
    nxt_retry_ms = retry_ms_ff;
    nxt_lk       = lk_ff;
    nxt_lk_sel   = lk_sel_ff;
    nxt_lk_bits  = lk_bits_ff;
    nxt_ilim     = ilim_ff;
    nxt_nvm      = nvm_ff;
    nxt_i2c      = i2c_ff;
    nxt_uv       = uv_ff;
    nxt_crc      = crc_ff;
    // Persistence timers restart whenever the condition drops out.
    if (!bemf_high) begin
      nxt_bemf_ms = '0;
    end else if (ms_tick && bemf_ms_ff != 16'hFFFF) begin
      nxt_bemf_ms = bemf_ms_ff + 1'b1;
    end
    if (!op_low) begin
      nxt_op_ms = '0;
    end else if (ms_tick && op_ms_ff != 10'(OPEN_PHASE_MS)) begin
      nxt_op_ms = op_ms_ff + 1'b1;
    end
    // Rotor lock response; the mode is captured at the event so a later
    // change of the selector cannot strand the FETs in a forced state.
    case (lk_ff)
      MFM_LK_IDLE: begin
        if (lock_ev && rotor_lock_response_sel_i != RSP_DISABLED) begin
          nxt_lk_sel   = rotor_lock_response_sel_i;
          nxt_lk_bits  = {op_ev, bemf_ev, ovs_cond};
          nxt_retry_ms = '0;
          nxt_lk = is_retry(rotor_lock_response_sel_i) ?
                   MFM_LK_RETRY : MFM_LK_HOLD;
        end
      end
      MFM_LK_HOLD: begin
        nxt_lk_bits = lk_bits_ff | {op_ev, bemf_ev, ovs_cond};
        if (clr_pulse && !lock_ev) begin
          nxt_lk      = MFM_LK_IDLE;
          nxt_lk_bits = '0;
        end
      end
      MFM_LK_RETRY: begin
        nxt_lk_bits = lk_bits_ff | {op_ev, bemf_ev, ovs_cond};
        if (ms_tick) begin
          if (retry_ms_ff + 16'h0001 >= lock_retry_time_i) begin
            nxt_lk      = MFM_LK_IDLE;
            nxt_lk_bits = '0;
          end else begin
            nxt_retry_ms = retry_ms_ff + 1'b1;
          end
        end
      end
      default: begin
        nxt_lk      = MFM_LK_IDLE;
        nxt_lk_bits = '0;
      end
    endcase
    // Current limit report; a live condition wins over the clear in every mode but 111b.
    if (adc_current_limit_i &&
        current_limit_response_sel_i != RSP_DISABLED) begin
      nxt_ilim = 1'b1;
    end else if (clr_pulse) begin
      nxt_ilim = 1'b0;
    end
    // NVM and I2C faults are events, so a set in the clear cycle wins.
    if (nvm_bad) begin
      nxt_nvm = 1'b1;
    end else if (clr_pulse) begin
      nxt_nvm = 1'b0;
    end
    if (i2c_bad) begin
      nxt_i2c = 1'b1;
    end else if (clr_pulse) begin
      nxt_i2c = 1'b0;
    end
    if (supply_low) begin
      nxt_uv = 1'b1;
    end else if (supply_low_response_sel_i == SEL_LATCH) begin
      if (clr_pulse) begin
        nxt_uv = 1'b0;
      end
    end else if (supply_ok) begin
      nxt_uv = 1'b0;
    end
    // Writes are accepted whatever the fault state.
    if (nvm_write_done_i) begin
      nxt_crc = nvm_write_crc_i;
    end
    // Tri-state faults override any forced lock state.
    if ((nxt_nvm && nvm_fault_response_sel_i == SEL_LATCH) ||
        (nxt_i2c && crc_err_response_sel_i == SEL_LATCH) ||
        nxt_uv) begin
      nxt_fet = MFM_FET_OFF;
    end else if (nxt_lk != MFM_LK_IDLE) begin
      nxt_fet = fet_of(nxt_lk_sel);
    end else begin
      nxt_fet = MFM_FET_NORMAL;
    end
    // Report-only lock keeps the pin released; the rest pull it low.
    nxt_pin = nxt_nvm | nxt_i2c |
              ((nxt_lk != MFM_LK_IDLE) && nxt_lk_sel != RSP_REPORT);
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_d_ff    <= 1'b0;
      boot_ff     <= 1'b0;
      req_ff      <= 1'b0;
      ms_cnt_ff   <= '0;
      bemf_ms_ff  <= '0;
      op_ms_ff    <= '0;
      retry_ms_ff <= '0;
      lk_ff       <= MFM_LK_IDLE;
      lk_sel_ff   <= RSP_DISABLED;
      lk_bits_ff  <= '0;
      ilim_ff     <= 1'b0;
      nvm_ff      <= 1'b0;
      i2c_ff      <= 1'b0;
      uv_ff       <= 1'b0;
      crc_ff      <= '0;
      fet_ff      <= MFM_FET_NORMAL;
      pin_ff      <= 1'b0;
    end else begin
      clr_d_ff    <= fault_clear_cmd_i;
      boot_ff     <= 1'b1;
      req_ff      <= ~boot_ff | wake_i;
      ms_cnt_ff   <= nxt_ms_cnt;
      bemf_ms_ff  <= nxt_bemf_ms;
      op_ms_ff    <= nxt_op_ms;
      retry_ms_ff <= nxt_retry_ms;
      lk_ff       <= nxt_lk;
      lk_sel_ff   <= nxt_lk_sel;
      lk_bits_ff  <= nxt_lk_bits;
      ilim_ff     <= nxt_ilim;
      nvm_ff      <= nxt_nvm;
      i2c_ff      <= nxt_i2c;
      uv_ff       <= nxt_uv;
      crc_ff      <= nxt_crc;
      fet_ff      <= nxt_fet;
      pin_ff      <= nxt_pin;
    end
  end

  // Open-drain pin: drive low only, never high.
  assign nvm_read_req_o           = req_ff;
  assign fault_out_n_o            = 1'b0;
  assign fault_out_n_oe_o         = pin_ff;
  assign fet_mode_o               = fet_ff;
  assign current_limit_status_o   = ilim_ff;
  assign rotor_lock_status_o      = lk_ff != MFM_LK_IDLE;
  assign overspeed_event_o        = lk_bits_ff[0];
  assign backemf_mismatch_event_o = lk_bits_ff[1];
  assign open_phase_event_o       = lk_bits_ff[2];
  assign nvm_error_status_o       = nvm_ff;
  assign i2c_crc_status_o         = i2c_ff;
  assign supply_low_status_o      = uv_ff;
  assign controller_fault_o       = ilim_ff | nvm_ff | i2c_ff | uv_ff |
                                    (lk_ff != MFM_LK_IDLE);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_ILIM_REPORT: assert property (
    adc_current_limit_i && current_limit_response_sel_i == RSP_REPORT
    |=> current_limit_status_o && controller_fault_o)
    else $error("current limit not reported");
  AST_ILIM_OFF: assert property (
    current_limit_response_sel_i == RSP_DISABLED && !ilim_ff
    |=> !ilim_ff) else $error("disabled current limit reported");
  AST_DET_EN: assert property (
    !overspeed_detect_en_i && !backemf_detect_en_i && !open_phase_detect_en_i
    |-> !lock_ev) else $error("lock from disabled detector");
  AST_OVS_LOCK: assert property (
    lk_ff == MFM_LK_IDLE && ovs_cond &&
    rotor_lock_response_sel_i == RSP_LATCH_OFF
    |=> rotor_lock_status_o && overspeed_event_o ##1 fet_mode_o == MFM_FET_OFF
        || nvm_ff || i2c_ff || uv_ff) else $error("overspeed lock missed");
  AST_OP_TIMER: assert property (
    op_ev |-> $past(op_low, 2)) else $error("open phase fired early");
  AST_OP_CL_DIS: assert property (
    motor_state_i == MFM_MS_CLOSED && open_phase_closedloop_disable_i
    |-> !op_qual) else $error("open phase checked in closed loop");
  AST_LATCH_HOLD: assert property (
    lk_ff == MFM_LK_HOLD && !clr_pulse |=> lk_ff == MFM_LK_HOLD)
    else $error("latched lock released without clear");
  AST_REPORT_PIN: assert property (
    lk_ff == MFM_LK_HOLD && lk_sel_ff == RSP_REPORT && !nvm_ff && !i2c_ff
    |-> !fault_out_n_oe_o) else $error("report-only lock drove pin");
  AST_NVM_FAULT: assert property (
    nvm_bad && nvm_fault_response_sel_i == SEL_LATCH
    |=> nvm_error_status_o && fault_out_n_oe_o && fet_mode_o == MFM_FET_OFF)
    else $error("NVM fault response wrong");
  AST_I2C_FAULT: assert property (
    i2c_bad |=> i2c_crc_status_o && controller_fault_o && fault_out_n_oe_o)
    else $error("I2C CRC fault missed");
  AST_UV_AUTO: assert property (
    uv_ff && supply_low_response_sel_i != SEL_LATCH && supply_ok
    |=> !uv_ff) else $error("undervoltage did not auto clear");
  AST_NVM_BOOT: assert property (
    $rose(boot_ff) |-> nvm_read_req_o) else $error("no boot NVM read");

  COV_RETRY: cover property (lk_ff == MFM_LK_RETRY ##1 lk_ff == MFM_LK_IDLE);
  COV_LATCH_CLR: cover property (lk_ff == MFM_LK_HOLD && clr_pulse);
  COV_NVM: cover property (nvm_bad);
  COV_UV: cover property ($fell(uv_ff));

endmodule : mfm_motor_fault_manager

// ### mfm_host_model.sv
/*
  Host-side model of the motor fault manager: pull-up on the fault wire
  and the host's clear-fault command.
  Assumes the bench tells it when the host wants the faults cleared.
*/
`timescale 1ns/1ps
// ==========================================================================
// Host model
// ==========================================================================
module mfm_host_model (
  input  wire logic clear_req_i,
  input  wire logic fault_out_n_i,
  input  wire logic fault_out_n_oe_i,
  output logic      fault_clear_cmd_o,
  output logic      fault_pin_o
);
  // The host passes the bench's clear request straight through, whether or not the cause has gone.
  assign fault_clear_cmd_o = clear_req_i;
  // Released wire reads the pull-up level, never a stale driven value.
  assign fault_pin_o = fault_out_n_oe_i ? fault_out_n_i : 1'b1;
endmodule : mfm_host_model

// ### tb_top.sv
/*
  Self-checking bench for the motor fault manager.
  Assumes one 50 MHz clock and a 4-cycle millisecond tick.
*/
`timescale 1ns/1ps
module tb_top import mfm_pkg::*;;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, lim = 1'b0, eo = 1'b0;
  logic eb = 1'b0, ep = 1'b0, cdis = 1'b0, wake = 1'b0, rd = 1'b0;
  logic par = 1'b1, wr = 1'b0, nsel = 1'b0, cen = 1'b0, pkt = 1'b0;
  logic cok = 1'b1, csel = 1'b0, usel = 1'b0;
  logic [2:0]  lsel = 3'h6, ksel = 3'h6, mst = 3'h4;
  logic [15:0] spd = 16'h0064, othr = 16'h1000, berr = 16'h0000;
  logic [15:0] rty = 16'h0004, vm = 16'h8000;
  logic [15:0] pers = 16'h0003, hyst = 16'h0100;
  logic [35:0] iph = {3{12'h200}};
  logic [7:0]  rcrc = 8'h00, wcrc = 8'h00;
  logic [7:0]  exp_lk [8] = '{8'h3B, 8'h3D, 8'h3F, 8'h3B, 8'h3D, 8'h3F,
                              8'h31, 8'h00};
  wire req, pn, oe, cf, cls, lks, ose, bee, ope, nve, crs, uvs, ccmd, pin;
  wire [1:0] fet;
  int errors = 0, comparisons = 0, cycles = 0, n, m;

  // Free-running 20 ns clock; the cycle count also cuts a hang short.
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      summarize();
    end
  end

  mfm_motor_fault_manager #(.MS_CYCLES(4)) DUT (
    .clk_i(clk), .arst_n_i(rst_n), .fault_clear_cmd_i(ccmd),
    .current_limit_response_sel_i(lsel), .adc_current_limit_i(lim),
    .overspeed_detect_en_i(eo), .backemf_detect_en_i(eb),
    .open_phase_detect_en_i(ep), .motor_speed_i(spd),
    .overspeed_threshold_i(othr), .backemf_error_i(berr),
    .backemf_mismatch_threshold_i(16'h0100),
    .backemf_persist_ms_i(pers), .phase_current_i(iph),
    .open_phase_current_threshold_i(12'h100), .motor_state_i(mst),
    .open_phase_closedloop_disable_i(cdis),
    .rotor_lock_response_sel_i(ksel), .lock_retry_time_i(rty),
    .wake_i(wake), .nvm_read_done_i(rd), .nvm_read_crc_i(rcrc),
    .nvm_parity_ok_i(par), .nvm_write_done_i(wr), .nvm_write_crc_i(wcrc),
    .nvm_fault_response_sel_i(nsel), .i2c_crc_en_i(cen),
    .i2c_pkt_done_i(pkt), .i2c_crc_ok_i(cok), .crc_err_response_sel_i(csel),
    .supply_voltage_i(vm), .supply_low_threshold_i(16'h1000),
    .supply_hysteresis_i(hyst), .supply_low_response_sel_i(usel),
    .nvm_read_req_o(req), .fault_out_n_o(pn), .fault_out_n_oe_o(oe),
    .fet_mode_o(fet), .controller_fault_o(cf),
    .current_limit_status_o(cls), .rotor_lock_status_o(lks),
    .overspeed_event_o(ose), .backemf_mismatch_event_o(bee),
    .open_phase_event_o(ope), .nvm_error_status_o(nve),
    .i2c_crc_status_o(crs), .supply_low_status_o(uvs));

  mfm_host_model host (.clear_req_i(clr), .fault_out_n_i(pn),
    .fault_out_n_oe_i(oe), .fault_clear_cmd_o(ccmd), .fault_pin_o(pin));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  // One-cycle pulse, then one idle cycle so the answer has landed.
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic wait_lock(int lim_c);
    for (n = 0; n < lim_c && lks !== 1'b1; n++) cyc(1);
  endtask : wait_lock
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // ==========================================================================
  // Main sequence; pin bit is the inverted wire so 1 means pulled low.
  // ==========================================================================
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    check("read_req", req, 8'h01);
    cyc(1);
    check("read_req", req, 8'h00);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    check("wake_req", req, 8'h01);
    pulse(rd);
    check("nvm_ok", {nve, ~pin, fet, cf}, 8'h00);
    par = 1'b0;
    pulse(rd);
    par = 1'b1;
    check("nvm_latch", {nve, ~pin, fet, cf}, 8'h1B);
    wcrc = 8'h5A;
    pulse(wr);
    pulse(clr);
    check("nvm_clr", {nve, ~pin, fet, cf}, 8'h00);
    rcrc = 8'h5A;
    pulse(rd);
    check("nvm_newcrc", nve, 8'h00);
    rcrc = 8'h00;
    nsel = 1'b1;
    pulse(rd);
    check("nvm_report", {nve, ~pin, fet, cf}, 8'h19);
    pulse(clr);
    check("nvm_rclr", {nve, ~pin, fet, cf}, 8'h00);
    cok = 1'b0;
    pulse(pkt);
    check("crc_off", {crs, ~pin, fet, cf}, 8'h00);
    cen = 1'b1;
    pulse(pkt);
    check("crc_latch", {crs, ~pin, fet, cf}, 8'h1B);
    pulse(clr);
    csel = 1'b1;
    pulse(pkt);
    check("crc_report", {crs, ~pin, fet, cf}, 8'h19);
    pulse(clr);
    check("crc_clr", {crs, ~pin, fet, cf}, 8'h00);
    lim = 1'b1;
    cyc(2);
    check("ilim", {cls, ~pin, fet, cf}, 8'h11);
    pulse(clr);
    check("ilim_live", {cls, ~pin, fet, cf}, 8'h11);
    lim = 1'b0;
    pulse(clr);
    check("ilim_clr", {cls, cf}, 8'h00);
    lsel = 3'h7;
    lim = 1'b1;
    cyc(3);
    check("ilim_off", {cls, cf}, 8'h00);
    lim = 1'b0;
    vm = 16'h1000;
    cyc(2);
    vm = 16'h8000;
    cyc(2);
    check("uv_latch", {uvs, ~pin, fet, cf}, 8'h13);
    pulse(clr);
    check("uv_clr", {uvs, fet, cf}, 8'h00);
    usel = 1'b1;
    vm = 16'h1000;
    cyc(2);
    vm = 16'h1100;
    cyc(3);
    check("uv_hyst", {uvs, fet, cf}, 8'h0B);
    vm = 16'h1101;
    cyc(2);
    check("uv_auto", {uvs, fet, cf}, 8'h00);
    eo = 1'b1;
    // Every lock response code, with a refused clear while the cause lives.
    for (m = 0; m < 8; m++) begin
      ksel = m[2:0];
      spd = 16'h1000;
      cyc(2);
      check("lock_eq", lks, 8'h00);
      spd = 16'h1001;
      cyc(2);
      check("lock", {lks, ose, ~pin, fet, cf}, exp_lk[m]);
      pulse(clr);
      check("lock_live", {lks, ose, ~pin, fet, cf}, exp_lk[m]);
      spd = 16'h0064;
      cyc(24);
      check("lock_hold", {lks, ose, ~pin, fet, cf},
            (m > 2 && m < 6) ? 8'h00 : exp_lk[m]);
      pulse(clr);
      check("lock_clr", {lks, ose, ~pin, fet, cf}, 8'h00);
    end
    ksel = 3'h6;
    eo = 1'b0;
    spd = 16'h1001;
    cyc(3);
    check("os_disabled", lks, 8'h00);
    spd = 16'h0064;
    eb = 1'b1;
    berr = 16'h0200;
    wait_lock(40);
    check("bemf_time", {7'h00, n >= 8 && n <= 20}, 8'h01);
    check("bemf_event", bee, 8'h01);
    berr = 16'h0000;
    eb = 1'b0;
    pulse(clr);
    ep = 1'b1;
    iph[23:12] = 12'h010;
    mst = MFM_MS_ALIGN;
    wait_lock(2100);
    check("op_align", lks, 8'h00);
    mst = MFM_MS_CLOSED;
    cdis = 1'b1;
    wait_lock(2100);
    check("op_cl_dis", lks, 8'h00);
    mst = MFM_MS_OPEN;
    spd = 16'h0013;
    wait_lock(2100);
    check("op_slow", lks, 8'h00);
    spd = 16'h0064;
    wait_lock(2100);
    check("op_time", {7'h00, n >= 1996 && n <= 2008}, 8'h01);
    check("op_event", ope, 8'h01);
    summarize();
  end
endmodule : tb_top
